// [core/tps_defs.svh]
// Register map, field positions and codes for the test pattern and pin route block.
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH
`define TPS_IDX_CMPL 8'h27
`define TPS_IDX_PSEL 8'h3e
`define TPS_IDX_TXCTL 8'h48
`define TPS_ADDR_CMPL 12'h09c
`define TPS_ADDR_PSEL 12'h0f8
`define TPS_ADDR_TXCTL 12'h120
`define TPS_TE_EN_BIT 4
`define TPS_CFG_HI 3
`define TPS_TX_EN_BIT 4
`define TPS_TX_HI_BIT 5
`define TPS_TXSEL_HI 6
`define TPS_TXSEL_LO 4
`define TPS_RXSEL_HI 2
`define TPS_RXSEL_LO 0
`define TPS_RST16 16'h0000
`define TPS_TX_CLEAR 6'h20
`define TPS_TX_Z3 6'h23
`define TPS_TX_Z4 6'h26
`define TPS_ZC_NONE 5'h00
`define TPS_ZC_THREE 5'h03
`define TPS_ZC_FOUR 5'h04
`define TPS_TE_NLP 4'h0
`define TPS_TE_ONE 4'h1
`define TPS_TE_ZERO 4'h2
`define TPS_TE_REP1 4'h3
`define TPS_TE_RAND 4'h9
`endif

// [core/tps_pkg.sv]
// Types shared by the test pattern and pin route block.
package tps_pkg;
    typedef enum logic [2:0] {
        TPS_PIN_NONE = 3'h0,
        TPS_PIN_RSV1 = 3'h1,
        TPS_PIN_RSV2 = 3'h2,
        TPS_PIN_LED = 3'h3,
        TPS_PIN_CRS = 3'h4,
        TPS_PIN_COL = 3'h5,
        TPS_PIN_INTPD = 3'h6,
        TPS_PIN_OFF = 3'h7
    } tps_pin_sel_t;
    typedef enum logic [2:0] {
        TPS_BUS_IDLE = 3'b001,
        TPS_BUS_WR = 3'b010,
        TPS_BUS_RD = 3'b100
    } tps_bus_state_t;
endpackage : tps_pkg

// [core/tps_top.sv]
// Test pattern control and delimiter pulse pin routing with AHB-Lite access.
`timescale 1ns/100ps
`include "tps_defs.svh"
// How it works
// - Bit 4 of the compliance register enables 10BASE-Te patterns; resets to zero.
// - Low four bits of the compliance register pick the 10BASE-Te pattern; reset zero.
// - Codes 0000..0011 give NLP, single one, single zero, repetitive ones.
// - Code 1001 sends random 10BASE-Te data; other codes are ambiguous.
// - A separate enable bit 4 in the upper control register enables 100BASE-TX tests.
// - The 100BASE-TX code is bit 5 of that register above the four-bit field.
// - Code 10,0011 three zeros, 10,0110 four zeros, 10,0000 clears shift register.
// - Transmit pin select bits 6:4 route the transmit delimiter pulse; reset 000.
// - Codes 011 LED, 100 carrier sense, 101 collision; 001 and 010 reserved.
// - Code 110 routes to interrupt/power-down pin; 111 gives no pulse output.
// - Receive pin select bits 2:0 route the receive pulse with the same map.
module tps_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic tx_sfd_pulse,
    input wire logic rx_sfd_pulse,
    output logic te_test_en,
    output logic [3:0] te_pattern,
    output logic te_nlp,
    output logic te_single_one,
    output logic te_single_zero,
    output logic te_rep_ones,
    output logic te_random,
    output logic tx_test_en,
    output logic [5:0] tx_pattern,
    output logic [4:0] tx_zero_count,
    output logic tx_shift_clear,
    output logic led_output_pin,
    output logic crs_pin,
    output logic col_pin,
    output logic interrupt_powerdown_pin
);
    import tps_pkg::*;

    // Widths of the register words, the pin set and the pulse sources.
    localparam int REG_W = 16;
    localparam int CODE_W = 6;
    localparam int PIN_N = 4;
    localparam int SRC_N = 2;

    logic [REG_W-1:0] cmpl_q;
    logic [REG_W-1:0] psel_q;
    logic [REG_W-1:0] txctl_q;
    logic [CODE_W-1:0] tx_pattern_q;
    logic [CODE_W-1:0] tx_code;
    logic tx_en_prev_q;
    logic tx_en_rise;
    tps_bus_state_t st_q;
    tps_bus_state_t st_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic [31:0] cmpl_word;
    logic [31:0] psel_word;
    logic [31:0] txctl_word;
    logic take;
    logic wr_phase;
    logic wr_cmpl;
    logic wr_psel;
    logic wr_txctl;
    logic [REG_W-1:0] wd;
    logic [REG_W-1:0] psel_wr_val;
    logic [SRC_N-1:0] sfd_in;
    wire logic [SRC_N-1:0] sfd_sync;
    logic [PIN_N-1:0] tx_route;
    logic [PIN_N-1:0] rx_route;
    wire logic [PIN_N-1:0] pin_out;

    // The slave never inserts wait states and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign take = hsel && hready && htrans[1];
    assign wd = hwdata[REG_W-1:0];
    assign addr_d = {haddr[11:2], 2'b00};

    // Each taken address phase opens one data phase.
    always_comb begin
        st_d = TPS_BUS_IDLE;
        if (take) begin
            st_d = hwrite ? TPS_BUS_WR : TPS_BUS_RD;
        end
    end

    // Bus phase state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= TPS_BUS_IDLE;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Address of the transfer whose data phase comes next.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 12'h000;
        end else if (ce && take) begin
            addr_q <= addr_d;
        end
    end

    // Write strobes for the data phase that follows a write address phase.
    assign wr_phase = ce && st_q == TPS_BUS_WR;
    assign wr_cmpl = wr_phase && addr_q == `TPS_ADDR_CMPL;
    assign wr_psel = wr_phase && addr_q == `TPS_ADDR_PSEL;
    assign wr_txctl = wr_phase && addr_q == `TPS_ADDR_TXCTL;

    // Only the two select fields of the pin route register hold state.
    always_comb begin
        psel_wr_val = `TPS_RST16;
        psel_wr_val[`TPS_TXSEL_HI:`TPS_TXSEL_LO] =
            wd[`TPS_TXSEL_HI:`TPS_TXSEL_LO];
        psel_wr_val[`TPS_RXSEL_HI:`TPS_RXSEL_LO] =
            wd[`TPS_RXSEL_HI:`TPS_RXSEL_LO];
    end

    // Compliance test register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmpl_q <= `TPS_RST16;
        end else if (wr_cmpl) begin
            cmpl_q <= wd;
        end
    end

    // Pin route register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psel_q <= `TPS_RST16;
        end else if (wr_psel) begin
            psel_q <= psel_wr_val;
        end
    end

    // Stand-in for the separate 100BASE-TX control register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txctl_q <= `TPS_RST16;
        end else if (wr_txctl) begin
            txctl_q <= wd;
        end
    end

    // Read words with the unused upper half held at zero.
    assign cmpl_word = {{(32-REG_W){1'b0}}, cmpl_q};
    assign psel_word = {{(32-REG_W){1'b0}}, psel_q};
    assign txctl_word = {{(32-REG_W){1'b0}}, txctl_q};

    // Unmapped addresses read as zero.
    always_comb begin
        unique case (addr_d)
            `TPS_ADDR_CMPL: rd_mux = cmpl_word;
            `TPS_ADDR_PSEL: rd_mux = psel_word;
            `TPS_ADDR_TXCTL: rd_mux = txctl_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is registered during the address phase.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ce && take && !hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    // The 100BASE-TX code keeps a zero between its high bit and the field.
    assign tx_code = {txctl_q[`TPS_TX_HI_BIT], 1'b0,
                      cmpl_q[`TPS_CFG_HI:0]};
    assign tx_en_rise = txctl_q[`TPS_TX_EN_BIT] && !tx_en_prev_q;

    // Delayed enable for the edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en_prev_q <= 1'b0;
        end else if (ce) begin
            tx_en_prev_q <= txctl_q[`TPS_TX_EN_BIT];
        end
    end

    // A new code is taken only when the enable rises.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_pattern_q <= 6'h00;
        end else if (ce && tx_en_rise) begin
            tx_pattern_q <= tx_code;
        end
    end

    assign te_test_en = cmpl_q[`TPS_TE_EN_BIT];
    assign te_pattern = cmpl_q[`TPS_CFG_HI:0];
    assign tx_test_en = txctl_q[`TPS_TX_EN_BIT] && tx_en_prev_q;
    assign tx_pattern = tx_pattern_q;

    // Ambiguous 10BASE-Te codes decode to no pattern.
    always_comb begin
        te_nlp = 1'b0;
        te_single_one = 1'b0;
        te_single_zero = 1'b0;
        te_rep_ones = 1'b0;
        te_random = 1'b0;
        if (te_test_en) begin
            unique case (te_pattern)
                `TPS_TE_NLP: te_nlp = 1'b1;
                `TPS_TE_ONE: te_single_one = 1'b1;
                `TPS_TE_ZERO: te_single_zero = 1'b1;
                `TPS_TE_REP1: te_rep_ones = 1'b1;
                `TPS_TE_RAND: te_random = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Zeros that follow each one in the 100BASE-TX pattern.
    always_comb begin
        tx_zero_count = `TPS_ZC_NONE;
        tx_shift_clear = 1'b0;
        if (tx_test_en) begin
            unique case (tx_pattern_q)
                `TPS_TX_Z3: tx_zero_count = `TPS_ZC_THREE;
                `TPS_TX_Z4: tx_zero_count = `TPS_ZC_FOUR;
                `TPS_TX_CLEAR: tx_shift_clear = 1'b1;
                default: tx_zero_count = `TPS_ZC_NONE;
            endcase
        end
    end

    assign sfd_in = {rx_sfd_pulse, tx_sfd_pulse};

    // Delimiter pulses arrive from another timing domain.
    for (genvar s = 0; s < SRC_N; s++) begin : g_sync
        logic sync1_q;
        logic sync2_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sync1_q <= 1'b0;
                sync2_q <= 1'b0;
            end else if (ce) begin
                sync1_q <= sfd_in[s];
                sync2_q <= sync1_q;
            end
        end
        assign sfd_sync[s] = sync2_q;
    end

    // Maps one select code to the pin that it drives.
    function automatic logic [3:0] tps_route(input logic [2:0] sel,
                                              input logic p);
        logic [3:0] r;
        r = 4'h0;
        unique case (tps_pin_sel_t'(sel))
            TPS_PIN_LED: r[0] = p;
            TPS_PIN_CRS: r[1] = p;
            TPS_PIN_COL: r[2] = p;
            TPS_PIN_INTPD: r[3] = p;
            default: r = 4'h0;
        endcase
        return r;
    endfunction : tps_route

    assign tx_route = tps_route(psel_q[`TPS_TXSEL_HI:`TPS_TXSEL_LO],
                                sfd_sync[0]);
    assign rx_route = tps_route(psel_q[`TPS_RXSEL_HI:`TPS_RXSEL_LO],
                                sfd_sync[1]);

    // A pin carries either pulse when both fields route to it.
    for (genvar p = 0; p < PIN_N; p++) begin : g_pin
        logic pin_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pin_q <= 1'b0;
            end else if (ce) begin
                pin_q <= tx_route[p] | rx_route[p];
            end
        end
        assign pin_out[p] = pin_q;
    end

    assign led_output_pin = pin_out[0];
    assign crs_pin = pin_out[1];
    assign col_pin = pin_out[2];
    assign interrupt_powerdown_pin = pin_out[3];
endmodule : tps_top

// [dv/tps_top_monitor.sv]
// Port assertions for the test pattern and pin route block.
`timescale 1ns/100ps
module tps_top_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_sfd_pulse,
    input wire logic rx_sfd_pulse,
    input wire logic te_test_en,
    input wire logic [3:0] te_pattern,
    input wire logic te_nlp,
    input wire logic te_random,
    input wire logic tx_test_en,
    input wire logic [5:0] tx_pattern,
    input wire logic [4:0] tx_zero_count,
    input wire logic tx_shift_clear,
    input wire logic led_output_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_nlp_decode: assert property (te_nlp ==
        (te_test_en && te_pattern == 4'h0)) else $error("nlp decode wrong");
    chk_rand_decode: assert property (te_random ==
        (te_test_en && te_pattern == 4'h9)) else $error("random decode wrong");
    chk_te_gate: assert property (!te_test_en |->
        !te_nlp && !te_random) else $error("pattern without enable");
    chk_zero_three: assert property (tx_test_en && tx_pattern == 6'h23
        |-> tx_zero_count == 5'h3) else $error("zero count not three");
    chk_zero_four: assert property (tx_test_en && tx_pattern == 6'h26
        |-> tx_zero_count == 5'h4) else $error("zero count not four");
    chk_shift_clear: assert property (tx_test_en && tx_pattern == 6'h20
        |-> tx_shift_clear) else $error("shift clear missing");
    chk_code_hold: assert property (tx_test_en && $past(tx_test_en)
        |-> $stable(tx_pattern)) else $error("code changed while enabled");
    chk_pin_cause: assert property ($rose(led_output_pin) |->
        $past(tx_sfd_pulse, 3) || $past(rx_sfd_pulse, 3))
        else $error("led pin rose without a delimiter pulse");
    cover property (tx_test_en && tx_pattern == 6'h23);
    cover property (te_random);
    cover property ($rose(led_output_pin));
endmodule : tps_top_monitor
bind tps_top tps_top_monitor u_tps_top_monitor (.clk, .rst, .tx_sfd_pulse,
    .rx_sfd_pulse, .te_test_en, .te_pattern, .te_nlp, .te_random, .tx_test_en,
    .tx_pattern, .tx_zero_count, .tx_shift_clear, .led_output_pin);

// [dv/tps_top_tb.sv]
// Self-checking bench for the test pattern and pin route block.
`timescale 1ns/100ps
`include "tps_defs.svh"
module tps_top_tb;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, txp = 0, rxp = 0, ce = 1;
    logic [11:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata, rd;
    logic hreadyout, te_en, nlp, one, zro, rep, rnd, tx_en, clr;
    logic led, crs, col, ipd, resp;
    logic [3:0] te_pat;
    logic [5:0] tx_pat;
    logic [4:0] zc;
    int miscompares = 0, compares = 0, m, e;
    always #5 clk = ~clk;
    tps_top u_tps_top (.clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp(resp), .tx_sfd_pulse(txp), .rx_sfd_pulse(rxp),
        .te_test_en(te_en),
        .te_pattern(te_pat), .te_nlp(nlp), .te_single_one(one),
        .te_single_zero(zro), .te_rep_ones(rep), .te_random(rnd),
        .tx_test_en(tx_en), .tx_pattern(tx_pat), .tx_zero_count(zc),
        .tx_shift_clear(clr), .led_output_pin(led), .crs_pin(crs),
        .col_pin(col), .interrupt_powerdown_pin(ipd));
    task automatic summarize;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wrdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 99) begin
                miscompares++;
                summarize();
            end
            @(posedge clk);
        end
    endtask : wrdy
    task automatic bus(input logic w, input logic [11:0] a, input int d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wrdy();
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
        rd = hrdata;
    endtask : bus
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    initial begin
        void'($urandom(32'h268f));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(0, `TPS_ADDR_CMPL, 0);
        cmp(rd, 0);
        cmp(resp, 0);
        bus(0, `TPS_ADDR_PSEL, 0);
        cmp(rd, 0);
        bus(0, 12'h004, 0);
        cmp(rd, 0);
        m = $urandom;
        bus(1, `TPS_ADDR_PSEL, m);
        bus(0, `TPS_ADDR_PSEL, 0);
        cmp(rd, m & 32'h77);
        for (e = 0; e < 16; e++) begin
            bus(1, `TPS_ADDR_CMPL, 32'h10 | e);
            settle();
            cmp({te_en, te_pat, nlp, one, zro, rep, rnd}, {1'b1, e[3:0],
                e == 0, e == 1, e == 2, e == 3, e == 9});
        end
        bus(1, `TPS_ADDR_CMPL, 0);
        settle();
        cmp({te_en, nlp}, 0);
        for (e = 0; e < 3; e++) begin
            bus(1, `TPS_ADDR_TXCTL, 0);
            bus(1, `TPS_ADDR_CMPL, (3 * e) & 15);
            bus(1, `TPS_ADDR_TXCTL, 32'h30);
            settle();
            m = 32'h20 + 3 * e;
            cmp({tx_en, tx_pat, zc, clr}, {1'b1, m[5:0],
                e == 0 ? 5'h0 : 5'(e + 2), e == 0});
        end
        bus(1, `TPS_ADDR_CMPL, 3);
        settle();
        cmp(tx_pat, 6'h26);
        ce <= 1'b0;
        bus(1, `TPS_ADDR_CMPL, 32'h1f);
        ce <= 1'b1;
        bus(0, `TPS_ADDR_CMPL, 0);
        cmp(rd, 3);
        for (m = 0; m < 16; m++) begin
            e = m & 7;
            bus(1, `TPS_ADDR_PSEL, m < 8 ? e << 4 : e);
            @(posedge clk);
            txp <= m < 8;
            rxp <= m >= 8;
            @(posedge clk);
            txp <= 1'b0;
            rxp <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            cmp({led, crs, col, ipd},
                {e == 3, e == 4, e == 5, e == 6});
            @(posedge clk);
            #1;
            cmp({led, crs, col, ipd}, 0);
        end
        summarize();
    end
endmodule : tps_top_tb
